// ---- design/isl_pkg.sv ----
package isl_pkg;

    // ----------------------------------------------------------------
    // register map, word indices on the avalon slave (address bits 5:2)
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_PRIMARY = 4'h0;  // primary_irq_status, read clears
    localparam logic [3:0] OFS_MASK = 4'h1;     // per-source mask
    localparam logic [3:0] OFS_EXTENDED = 4'h2; // extended_irq_status, read clears
    localparam logic [3:0] OFS_CODE_RX = 4'h3;  // code_receive_status
    localparam logic [3:0] OFS_SQ_CFG = 4'h4;   // sq_transmit_config
    localparam logic [3:0] OFS_SQ_CODE = 4'h5;  // sq_receive_code
    localparam logic [3:0] OFS_CH1_CODE = 4'h6; // chan1_receive_code
    localparam logic [3:0] OFS_MODE = 4'h7;     // bus generation and timing mode
    localparam logic [3:0] OFS_MON_CTRL = 4'h8; // monitor_control
    localparam logic [3:0] OFS_MON_STAT = 4'h9; // monitor_status_reg, read clears
    localparam logic [3:0] OFS_MON_DATA = 4'ha; // last stored monitor byte

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PRI_EXT_BIT = 0;   // extended_summary_flag
    localparam int PRI_CODE_BIT = 2;  // code_change_flag
    localparam int EXT_MON_BIT = 4;   // monitor_status_flag inside extended
    localparam int CH_C0 = 0;         // code channel indices
    localparam int CH_SQ = 1;
    localparam int CH_C1 = 2;
    localparam int CRX_FLAG_LSB = 4;  // change flags in code_receive_status
    localparam int CFG_SQ_EN = 0;     // sq_change_enable
    localparam int CFG_C1_EN = 1;     // chan1_change_enable
    localparam int MODE_GEN_TWO = 0;  // 1: serial_bus_gen_two, 0: serial_bus_gen_one
    localparam int MODE_TERMINAL = 1; // terminal timing mode
    localparam int MC_RX_EN = 0;      // monitor_rx_enable
    localparam int MC_HS = 1;         // monitor_handshake_ctrl
    localparam int MC_TX_EN = 2;      // monitor_tx_enable
    localparam int MS_DATA = 0;       // monitor_data_received
    localparam int MS_END = 1;        // monitor_end_of_rx
    localparam int MS_ACK = 2;        // monitor_data_acked
    localparam int MS_ABORT = 3;      // monitor_data_abort

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [3:0] CODE_RST = 4'hf;
    localparam logic [1:0] MODE_RST = 2'h3;
    localparam logic [1:0] SQCFG_RST = 2'h0;
    localparam logic [2:0] MCTL_RST = 3'h0;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic byte_valid;  // a monitor byte has arrived
        logic first;       // it is the first byte of a packet
        logic chan;        // monitor channel 0 or 1
        logic [7:0] data;  // the byte
        logic rx_end;      // end of reception seen
        logic acked;       // far end acknowledged our byte
        logic abort;       // far end aborted the transfer
    } isl_mon_in_type;

    typedef struct packed {
        logic [2:0][3:0] sync1;     // code pins, first stage
        logic [2:0][3:0] sync2;     // code pins, second stage
        logic [2:0][3:0] seen;      // last code observed on the pins
        logic [2:0][3:0] code;      // code shown to software
        logic [2:0][3:0] code_pend; // latest code waiting behind it
        logic [2:0] unread;         // code not yet read
        logic [2:0] pend;           // a further change is waiting
        logic [2:0] chg;            // raw change flags
        logic [2:0] clk_sync;       // bus_data_clock two stages plus previous
        logic [2:0] mx_sync;        // monitor_tx_bit two stages plus previous
        logic [7:0] prim;           // pending primary events
        logic [7:0] mask;
        logic [7:0] ext;
        logic [1:0] mode;
        logic [1:0] sqcfg;
        logic [2:0] mctl;
        logic [3:0] mstat;
        logic [7:0] mdata;
        logic in_pkt;               // inside a monitor packet
        logic mrx;                  // monitor_rx_bit
        logic irq_oe;               // open drain pull-down enable
        logic irq_o;                // drive level, always low
        logic waitreq;
        logic [31:0] rdata;
        logic [7:0] snap;           // bits returned by the open read
    } isl_state_type;

endpackage : isl_pkg

// ---- design/isl_irq_logic.sv ----
`timescale 1ns/100ps
module isl_irq_logic
    import isl_pkg::*;
(
    input wire logic clk,                        // 250 mhz system clock
    input wire logic rst_n,                      // asynchronous reset
    input wire logic ce,                         // clock enable, freezes state
    input wire logic [5:0] avs_address,          // byte address
    input wire logic avs_read,                   // read request
    input wire logic avs_write,                  // write request
    input wire logic [3:0] avs_byteenable,       // byte lanes
    input wire logic [31:0] avs_writedata,       // write data
    output logic [31:0] avs_readdata,            // read data
    output logic avs_waitrequest,                // stall
    input wire logic [7:0] prim_event,           // primary source pulses
    input wire logic [7:0] ext_event,            // extended source pulses
    input wire isl_mon_in_type mon_in,           // monitor channel events
    input wire logic [3:0] chan0_code_pin,       // received chan0 code, async
    input wire logic [3:0] sq_code_pin,          // received sq code, async
    input wire logic [3:0] chan1_code_pin,       // received chan1 code, async
    input wire logic bus_data_clock,             // serial bus clock, async
    input wire logic monitor_tx_bit,             // handshake bit from far end
    output logic monitor_rx_bit,                 // handshake bit to far end
    output logic irq_o,                          // open drain level, low
    output logic irq_oe                          // pulls request line low
);

    // ----------------------------------------------------------------
    // read multiplexer
    // ----------------------------------------------------------------
    function automatic logic [7:0] reg_read(input logic [3:0] idx, input isl_state_type st);
        logic [7:0] r;
        logic [2:0] vis;
        r = 8'h00;
        vis = {st.chg[CH_C1] & st.sqcfg[CFG_C1_EN], st.chg[CH_SQ] & st.sqcfg[CFG_SQ_EN],
            st.chg[CH_C0]};
        case (idx)
            OFS_PRIMARY:
            begin
                r = st.prim & ~st.mask; // masked events stay hidden; summary and code-change bits are shown regardless
                r[PRI_EXT_BIT] = |st.ext;
                r[PRI_CODE_BIT] = |vis;
            end
            OFS_MASK: r = st.mask;
            OFS_EXTENDED: r = st.ext;
            OFS_CODE_RX: r = {1'b0, vis, st.code[CH_C0]};
            OFS_SQ_CFG: r = {6'h00, st.sqcfg};
            OFS_SQ_CODE: r = {4'h0, st.code[CH_SQ]};
            OFS_CH1_CODE: r = {4'h0, st.code[CH_C1]};
            OFS_MODE: r = {6'h00, st.mode};
            OFS_MON_CTRL: r = {5'h00, st.mctl};
            OFS_MON_STAT: r = {4'h0, st.mstat};
            OFS_MON_DATA: r = st.mdata;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : reg_read

    isl_state_type s;
    isl_state_type next_s;
    logic [3:0] idx;
    logic accept;
    logic acc_rd;
    logic acc_wr;
    logic dclk_rise;
    logic req;
    logic [2:0] vis_chg;

    // ----------------------------------------------------------------
    // shared decode
    // ----------------------------------------------------------------
    assign idx = avs_address[5:2];
    assign accept = (avs_read | avs_write) & ~s.waitreq;
    assign acc_rd = accept & avs_read;
    assign acc_wr = accept & avs_write & avs_byteenable[0];
    assign dclk_rise = s.clk_sync[1] & ~s.clk_sync[2];
    assign vis_chg = {s.chg[CH_C1] & s.sqcfg[CFG_C1_EN], s.chg[CH_SQ] & s.sqcfg[CFG_SQ_EN],
        s.chg[CH_C0]};
    // summary and code-change set even when masked; mask only gates request
    assign req = |(s.prim & ~s.mask & 8'hfa) | (|s.ext & ~s.mask[PRI_EXT_BIT])
        | (|vis_chg & ~s.mask[PRI_CODE_BIT]);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic gen2;
        logic term;
        logic mx_fall;
        logic [2:0] unlock;
        logic [2:0] active;
        logic store;
        logic [3:0] mkeep;
        next_s = s;
        gen2 = s.mode[MODE_GEN_TWO];
        term = s.mode[MODE_TERMINAL];
        mx_fall = s.mx_sync[2] & ~s.mx_sync[1];
        unlock = 3'h0;
        store = 1'b0;
        active = 3'h0;
        mkeep = 4'h0;

        // pin synchronisers, first stage read only by the second
        next_s.sync1 = {chan1_code_pin, sq_code_pin, chan0_code_pin};
        next_s.sync2 = s.sync1;
        next_s.clk_sync = {s.clk_sync[1:0], bus_data_clock};
        next_s.mx_sync = {s.mx_sync[1:0], monitor_tx_bit};

        // bus slave: one wait cycle, then answer; snapshot what was returned
        next_s.waitreq = 1'b1;
        if (s.waitreq && (avs_read || avs_write))
        begin
            next_s.waitreq = 1'b0;
            next_s.rdata = avs_read ? {24'h000000, reg_read(idx, s)} : 32'h00000000;
            next_s.snap = avs_read ? reg_read(idx, s) : 8'h00;
        end

        // writes
        if (acc_wr)
        begin
            case (idx)
                OFS_MASK: next_s.mask = avs_writedata[7:0];
                OFS_SQ_CFG: next_s.sqcfg = avs_writedata[1:0];
                OFS_MODE: next_s.mode = avs_writedata[1:0];
                OFS_MON_CTRL: next_s.mctl = avs_writedata[2:0];
                default: next_s.sqcfg = s.sqcfg;
            endcase
        end

        // read side effects, only bits that were returned, once per access
        if (acc_rd)
        begin
            case (idx)
                OFS_PRIMARY: next_s.prim = s.prim & ~(s.snap & 8'hfa);
                OFS_EXTENDED: next_s.ext = s.ext & ~s.snap; // summary follows
                OFS_CODE_RX:
                begin
                    next_s.chg = s.chg & ~s.snap[CRX_FLAG_LSB +: 3];
                    unlock[CH_C0] = 1'b1;
                end
                OFS_SQ_CODE: unlock[CH_SQ] = 1'b1;
                OFS_CH1_CODE: unlock[CH_C1] = 1'b1;
                OFS_MON_STAT: next_s.mstat = s.mstat & ~s.snap[3:0];
                default: next_s.snap = s.snap;
            endcase
        end

        // event sets come after clears so a same-cycle event wins
        next_s.prim = next_s.prim | (prim_event & 8'hfa);
        next_s.ext = next_s.ext | ext_event;

        // code channels: two deep, first code held, later ones overwrite
        active = {gen2 & term, 1'b1, 1'b1};
        for (int i = 0; i < 3; i++)
        begin
            if (unlock[i])
            begin
                if (s.pend[i])
                begin
                    next_s.code[i] = s.code_pend[i];
                    next_s.pend[i] = 1'b0;
                    next_s.chg[i] = 1'b1;
                end
                else
                begin
                    next_s.unread[i] = 1'b0;
                end
            end
            next_s.seen[i] = s.sync2[i];
            if (active[i] && s.sync2[i] != s.seen[i])
            begin
                if (!next_s.unread[i])
                begin
                    next_s.code[i] = s.sync2[i];
                    next_s.unread[i] = 1'b1;
                    // raw flag kept even while disabled, shown once enabled
                    next_s.chg[i] = 1'b1;
                end
                else
                begin
                    next_s.code_pend[i] = s.sync2[i];
                    next_s.pend[i] = 1'b1;
                end
            end
        end

        mkeep = next_s.mstat;
        // monitor channel; non-terminal gen two ignores channel 1
        if (gen2)
        begin
            if (mon_in.byte_valid && (term || !mon_in.chan))
            begin
                if (mon_in.first)
                begin
                    next_s.in_pkt = 1'b1;
                end
                // without handshake only a packet's first byte is flagged
                if (s.mctl[MC_RX_EN] && !s.mctl[MC_HS] && mon_in.first)
                begin
                    store = 1'b1;
                end
            end
            // handshake: every byte taken on tx bit fall
            if (s.mctl[MC_RX_EN] && s.mctl[MC_HS] && mx_fall)
            begin
                store = 1'b1;
                next_s.mrx = 1'b0;
            end
            if (!s.mctl[MC_HS] || s.mx_sync[1])
            begin
                next_s.mrx = 1'b1;
            end
            if (store)
            begin
                next_s.mdata = mon_in.data;
                next_s.mstat[MS_DATA] = 1'b1;
            end
            if (mon_in.rx_end && s.mctl[MC_RX_EN])
            begin
                next_s.mstat[MS_END] = 1'b1;
                next_s.in_pkt = 1'b0;
            end
            if (s.mctl[MC_TX_EN])
            begin
                // one enable for both transmit results
                next_s.mstat[MS_ACK] = next_s.mstat[MS_ACK] | mon_in.acked;
                next_s.mstat[MS_ABORT] = next_s.mstat[MS_ABORT] | mon_in.abort;
            end
            // only fresh status bits raise the summary, so an extended read sticks
            next_s.ext[EXT_MON_BIT] = next_s.ext[EXT_MON_BIT] | (|(next_s.mstat & ~mkeep));
        end
        else if (mon_in.byte_valid)
        begin
            // gen one: each byte flagged directly, control and status unused
            next_s.mdata = mon_in.data;
            next_s.ext[EXT_MON_BIT] = 1'b1;
        end

        // request moves only on bus clock rise; level, held while pending
        if (dclk_rise)
        begin
            next_s.irq_oe = req;
        end
        next_s.irq_o = 1'b0;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.sync1 <= {3{CODE_RST}};
            s.sync2 <= {3{CODE_RST}};
            s.seen <= {3{CODE_RST}};
            s.code <= {3{CODE_RST}};
            s.code_pend <= {3{CODE_RST}};
            s.mask <= MASK_RST;
            s.mode <= MODE_RST;
            s.sqcfg <= SQCFG_RST;
            s.mctl <= MCTL_RST;
            s.mrx <= 1'b1;
            s.waitreq <= 1'b1;
        end
        else if (ce)
        begin
            s <= next_s;
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign monitor_rx_bit = s.mrx;
    assign irq_o = s.irq_o;
    assign irq_oe = s.irq_oe;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_irq_on_dclk;
        @(posedge clk) disable iff (!rst_n)
        (s.irq_oe != $past(s.irq_oe)) |-> $past(dclk_rise);
    endproperty
    a_irq_on_dclk: assert property (p_irq_on_dclk) else $error("irq moved off clock rise");

    property p_irq_follows;
        @(posedge clk) disable iff (!rst_n)
        (dclk_rise && ce) |=> (s.irq_oe == $past(req));
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq not request level");

    property p_one_answer;
        @(posedge clk) disable iff (!rst_n)
        (!s.waitreq && ce) |=> s.waitreq;
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("answer held twice");

    property p_prim_clear;
        @(posedge clk) disable iff (!rst_n)
        (acc_rd && ce && idx == OFS_PRIMARY && s.snap[1] && !prim_event[1]) |=> !s.prim[1];
    endproperty
    a_prim_clear: assert property (p_prim_clear) else $error("primary bit not cleared");

    property p_masked_kept;
        @(posedge clk) disable iff (!rst_n)
        (acc_rd && idx == OFS_PRIMARY && s.mask[3] && s.prim[3]) |=> s.prim[3];
    endproperty
    a_masked_kept: assert property (p_masked_kept) else $error("masked event lost");

    property p_code_flag_stays;
        @(posedge clk) disable iff (!rst_n)
        (acc_rd && idx == OFS_PRIMARY && s.chg[CH_C0]) |=> s.chg[CH_C0];
    endproperty
    a_code_flag_stays: assert property (p_code_flag_stays) else $error("code flag cleared");

    property p_all_masked;
        @(posedge clk) disable iff (!rst_n)
        (s.mask == 8'hff && dclk_rise && ce) |=> !s.irq_oe;
    endproperty
    a_all_masked: assert property (p_all_masked) else $error("request under full mask");

    property p_chan1_mode;
        @(posedge clk) disable iff (!rst_n)
        (!s.chg[CH_C1] ##1 s.chg[CH_C1]) |-> $past(s.mode) == 2'h3;
    endproperty
    a_chan1_mode: assert property (p_chan1_mode) else $error("chan1 flag outside mode");

    property p_mdr_enable;
        @(posedge clk) disable iff (!rst_n)
        $rose(s.mstat[MS_DATA]) |-> $past(s.mctl[MC_RX_EN]);
    endproperty
    a_mdr_enable: assert property (p_mdr_enable) else $error("data status w/o enable");

    property p_ext_clear;
        @(posedge clk) disable iff (!rst_n)
        (acc_rd && ce && idx == OFS_EXTENDED && s.snap == s.ext && ext_event == 8'h00
            && !mon_in.byte_valid && !mon_in.rx_end && !mon_in.acked && !mon_in.abort
            && !(s.mx_sync[2] && !s.mx_sync[1])) |=> (s.ext == 8'h00);
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("extended not cleared");

    // cover points for the main scenarios
    logic unlock_pend_seen;
    assign unlock_pend_seen = acc_rd && idx == OFS_CODE_RX && s.pend[CH_C0];
    cover property (@(posedge clk) disable iff (!rst_n) $rose(s.irq_oe));
    cover property (@(posedge clk) disable iff (!rst_n) unlock_pend_seen);
    cover property (@(posedge clk) disable iff (!rst_n)
        acc_rd && idx == OFS_PRIMARY && |(s.prim & s.mask));
    cover property (@(posedge clk) disable iff (!rst_n) $fell(s.mrx));

endmodule : isl_irq_logic

// ---- testbench/isl_host_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// host side of the request line
// ----------------------------------------
module isl_host_model
(
    input wire logic irq_o,  // drive level from the device
    input wire logic irq_oe, // pull-down enable from the device
    output logic irq_line,   // resolved line level
    output int falls         // edges seen by an edge-triggered controller
);
    // the pull-up wins whenever the device lets go of the line
    assign irq_line = irq_oe ? irq_o : 1'b1;
    // an edge-triggered controller only notices falling edges
    initial falls = 0;
    always @(negedge irq_line)
        falls <= falls + 1;
endmodule : isl_host_model

// ---- testbench/isdn_interrupt_status_logic_tb.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// bench for the interrupt status block
// ----------------------------------------
module isdn_interrupt_status_logic_tb;
    import isl_pkg::*;
    logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, bus_data_clock = 0;
    logic [5:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic avs_waitrequest, monitor_rx_bit, irq_o, irq_oe, irq_line;
    logic [7:0] prim_event = '0, ext_event = '0;
    logic [3:0] chan0_code_pin = 4'hf, sq_code_pin = 4'hf, chan1_code_pin = 4'hf;
    logic mon_tx = 1'b1;
    logic [2:0] dcnt = '0;
    isl_mon_in_type mon_in = '0;
    int num_errors = 0, n_tests = 0, falls, n0;
    isl_irq_logic isl_irq_logic_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(4'h1), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .prim_event(prim_event), .ext_event(ext_event),
        .mon_in(mon_in), .chan0_code_pin(chan0_code_pin), .sq_code_pin(sq_code_pin),
        .chan1_code_pin(chan1_code_pin), .bus_data_clock(bus_data_clock),
        .monitor_tx_bit(mon_tx),
        .monitor_rx_bit(monitor_rx_bit), .irq_o(irq_o), .irq_oe(irq_oe));
    isl_host_model isl_host_model_inst (.irq_o(irq_o), .irq_oe(irq_oe),
        .irq_line(irq_line), .falls(falls));
    // 250 mhz clock; serial bus clock divided by eight
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        dcnt <= dcnt + 3'h1;
        bus_data_clock <= dcnt[2];
    end
    // verdict, reached from the end of the sequence and from every timeout
    task stop_test;
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk
    // one avalon access; held until waitrequest is seen low at an edge
    task acc(input logic w, input logic [3:0] r, input logic [7:0] d);
        int i;
        avs_address <= {r, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_read <= ~w;
        avs_write <= w;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        if (i >= 50)
        begin
            num_errors++;
            stop_test;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (!w)
            chk(avs_readdata, {24'h0, d});
        @(posedge clk);
    endtask : acc
    task rd(input logic [3:0] r, input logic [7:0] e);
        acc(1'b0, r, e);
    endtask : rd
    // bounded wait for the request line to reach a level
    task line_is(input logic lvl);
        int i;
        for (i = 0; i < 60 && irq_line !== lvl; i++)
            @(posedge clk);
        chk({31'h0, irq_line}, {31'h0, lvl});
        if (i >= 60)
            stop_test;
    endtask : line_is
    task pulse(input logic [7:0] p, input logic [7:0] x);
        prim_event <= p;
        ext_event <= x;
        @(posedge clk);
        prim_event <= '0;
        ext_event <= '0;
        repeat (4) @(posedge clk);
    endtask : pulse
    task mon(input logic f);
        mon_in.byte_valid <= 1'b1;
        mon_in.first <= f;
        @(posedge clk);
        mon_in <= '0;
        repeat (2) @(posedge clk);
    endtask : mon
    // far end reports both transmit results in one cycle
    task txres;
        mon_in.acked <= 1'b1;
        mon_in.abort <= 1'b1;
        @(posedge clk);
        mon_in <= '0;
        repeat (2) @(posedge clk);
    endtask : txres
    task pin0(input logic [3:0] c);
        chan0_code_pin <= c;
        repeat (6) @(posedge clk);
    endtask : pin0
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        line_is(1'b1);
        rd(OFS_MASK, MASK_RST);
        rd(OFS_MODE, {6'h0, MODE_RST});
        pulse(8'h02, 8'h00);
        line_is(1'b0);
        rd(OFS_PRIMARY, 8'h02);
        line_is(1'b1);
        rd(OFS_PRIMARY, 8'h00);
        acc(1'b1, OFS_MASK, 8'h08);
        pulse(8'h08, 8'h00);
        rd(OFS_PRIMARY, 8'h00);
        repeat (20) @(posedge clk);
        line_is(1'b1);
        acc(1'b1, OFS_MASK, 8'h00);
        rd(OFS_PRIMARY, 8'h08);
        pulse(8'h00, 8'h02);
        rd(OFS_PRIMARY, 8'h01);
        rd(OFS_PRIMARY, 8'h01);
        rd(OFS_EXTENDED, 8'h02);
        rd(OFS_PRIMARY, 8'h00);
        line_is(1'b1);
        // three codes before service: first and last survive
        pin0(4'h1);
        pin0(4'h2);
        pin0(4'h3);
        line_is(1'b0);
        rd(OFS_PRIMARY, 8'h04);
        rd(OFS_CODE_RX, 8'h11);
        rd(OFS_CODE_RX, 8'h13);
        rd(OFS_CODE_RX, 8'h03);
        rd(OFS_PRIMARY, 8'h00);
        sq_code_pin <= 4'h5;
        repeat (6) @(posedge clk);
        rd(OFS_CODE_RX, 8'h03);
        acc(1'b1, OFS_SQ_CFG, 8'h01);
        rd(OFS_PRIMARY, 8'h04);
        rd(OFS_CODE_RX, 8'h23);
        rd(OFS_SQ_CODE, 8'h05);
        // chan1 change in gen-two terminal mode, shown once enabled
        chan1_code_pin <= 4'h6;
        repeat (6) @(posedge clk);
        acc(1'b1, OFS_SQ_CFG, 8'h03);
        rd(OFS_CODE_RX, 8'h43);
        rd(OFS_CH1_CODE, 8'h06);
        // edge-triggered host: mask everything, then restore
        pulse(8'h02, 8'h00);
        line_is(1'b0);
        n0 = falls;
        acc(1'b1, OFS_MASK, 8'hff);
        line_is(1'b1);
        acc(1'b1, OFS_MASK, 8'h00);
        line_is(1'b0);
        chk(falls, n0 + 1);
        rd(OFS_PRIMARY, 8'h02);
        // monitor receive without handshake: first byte only
        acc(1'b1, OFS_MON_CTRL, 8'h01);
        mon(1'b1);
        rd(OFS_MON_STAT, 8'h01);
        mon(1'b0);
        rd(OFS_MON_STAT, 8'h00);
        acc(1'b1, OFS_MON_CTRL, 8'h00);
        mon(1'b1);
        rd(OFS_MON_STAT, 8'h00);
        // handshake receive: byte taken on tx bit fall, rx bit answers
        acc(1'b1, OFS_MON_CTRL, 8'h03);
        chk({31'h0, monitor_rx_bit}, 32'h1);
        mon_in.data <= 8'h5a;
        mon_tx <= 1'b0;
        repeat (6) @(posedge clk);
        chk({31'h0, monitor_rx_bit}, 32'h0);
        rd(OFS_MON_DATA, 8'h5a);
        rd(OFS_MON_STAT, 8'h01);
        mon_in <= '0;
        mon_tx <= 1'b1;
        repeat (6) @(posedge clk);
        chk({31'h0, monitor_rx_bit}, 32'h1);
        // transmit results share one enable
        acc(1'b1, OFS_MON_CTRL, 8'h04);
        txres;
        rd(OFS_MON_STAT, 8'h0c);
        acc(1'b1, OFS_MON_CTRL, 8'h00);
        txres;
        rd(OFS_MON_STAT, 8'h00);
        rd(OFS_EXTENDED, 8'h10);
        // non-terminal gen two: monitor and code channel 1 ignored
        acc(1'b1, OFS_MODE, 8'h01);
        acc(1'b1, OFS_MON_CTRL, 8'h01);
        mon_in.chan <= 1'b1;
        @(posedge clk);
        mon(1'b1);
        rd(OFS_MON_STAT, 8'h00);
        chan1_code_pin <= 4'h7;
        repeat (6) @(posedge clk);
        rd(OFS_CODE_RX, 8'h03);
        // gen one: each byte flagged straight in extended status
        acc(1'b1, OFS_MODE, 8'h00);
        mon(1'b0);
        rd(OFS_EXTENDED, 8'h10);
        rd(OFS_MON_STAT, 8'h00);
        stop_test;
    end
endmodule : isdn_interrupt_status_logic_tb
